// ---- pkg/pats_pkg.sv ----
// Constants, register map and types of the PWM and conversion-trigger block
`default_nettype none
package pats_pkg;
  // ****************************************
  // Clock and carrier timing
  // ****************************************
  localparam int CLK_HZ  = 25_000_000;
  localparam int PWM_HZ  = 20_000;
  localparam int TRIG_HZ = 10_000;
  localparam int CNT_W   = 16;
  localparam logic [CNT_W-1:0] PWM_PERIOD_RST  = CNT_W'(CLK_HZ / PWM_HZ);
  localparam logic [CNT_W-1:0] TRIG_PERIOD_RST = CNT_W'(CLK_HZ / TRIG_HZ);
  localparam logic [7:0]       DEAD_TIME_RST   = 8'h19;
  localparam logic [7:0]       WATERMARK_RST   = 8'h03;

  // ****************************************
  // Time base channel indices of the timer array
  // ****************************************
  localparam logic [4:0] PWM_TIME_BASE    = 5'h00;
  localparam logic [4:0] LOCAL_BASE_TWO   = 5'h08;
  localparam logic [4:0] LOCAL_BASE_THREE = 5'h10;
  localparam logic [4:0] GLOBAL_BASE_ONE  = 5'h16;
  localparam logic [4:0] TRIGGER_TIME_BASE = 5'h17;
  localparam int         LOCAL_FANOUT     = 7;
  localparam int         NUM_BASES        = 5;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_PWM_PERIOD  = 8'h04;
  localparam logic [7:0] OFS_TRIG_PERIOD = 8'h08;
  localparam logic [7:0] OFS_PWM_INIT    = 8'h0c;
  localparam logic [7:0] OFS_TRIG_INIT   = 8'h10;
  localparam logic [7:0] OFS_CMP_BASE    = 8'h14;
  localparam logic [7:0] OFS_DEAD_TIME   = 8'h24;
  localparam logic [7:0] OFS_WATERMARK   = 8'h28;
  localparam logic [7:0] OFS_FIFO_DATA   = 8'h2c;
  localparam logic [7:0] OFS_STATUS      = 8'h30;
  localparam logic [7:0] OFS_COUNTERS    = 8'h34;
  localparam logic [7:0] CMP_STRIDE      = 8'h04;

  // CTRL fields
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_BOTH  = 1;
  localparam int CTRL_DEBUG = 2;
  // STATUS fields
  localparam int STAT_FLAG  = 0;
  localparam int STAT_BUSY  = 1;
  localparam int STAT_OVF   = 2;
  localparam int STAT_EMPTY = 3;
  localparam int STAT_LEVEL = 8;
  // Compare register fields
  localparam int CMP_B_LSB  = 16;

  // ****************************************
  // Conversion list
  // ****************************************
  localparam logic       SEL_CURRENTS = 1'b0;
  localparam logic       SEL_DCBUS    = 1'b1;
  localparam logic [1:0] TAG_PHASE_A  = 2'h0;
  localparam logic [1:0] TAG_PHASE_B  = 2'h1;
  localparam logic [1:0] TAG_DCBUS    = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CURR = 2'b01,
    SEQ_PUSH = 2'b10,
    SEQ_VOLT = 2'b11
  } pats_seq_t;
endpackage
`default_nettype wire

// ---- hw/pats_top.sv ----
// Three-phase up-counting PWM with dead time and synchronised conversion trigger
//
// The implementer's own choices: the APB interface to the registers and the address map.
`default_nettype none
module pats_top #(
  parameter int RES_W      = 12,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [7:0]        i_paddr,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [31:0]       i_pwdata,
  output var  logic [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output var  logic              o_phase_a_high_gate,
  output var  logic              o_phase_a_low_gate,
  output var  logic              o_phase_b_high_gate,
  output var  logic              o_phase_b_low_gate,
  output var  logic              o_phase_c_high_gate,
  output var  logic              o_phase_c_low_gate,
  output var  logic              o_trig_debug,
  output var  logic              o_converter_zero_start,
  output var  logic              o_converter_one_start,
  output var  logic              o_conv_sel,
  input  wire logic              i_converter_zero_done,
  input  wire logic [RES_W-1:0]  i_converter_zero_data,
  input  wire logic              i_converter_one_done,
  input  wire logic [RES_W-1:0]  i_converter_one_data,
  output var  logic              o_watermark_irq
);
  localparam int CW    = pats_pkg::CNT_W;
  localparam int AW    = $clog2(FIFO_DEPTH);
  localparam int FW    = RES_W + 4;
  localparam int NCH   = 4;
  localparam int TRCH  = 3;
  localparam logic [4:0] CH_BASE [2] = '{pats_pkg::PWM_TIME_BASE, pats_pkg::TRIGGER_TIME_BASE};

  function automatic logic is_time_base(input logic [4:0] idx);
    is_time_base = idx == pats_pkg::PWM_TIME_BASE || idx == pats_pkg::LOCAL_BASE_TWO ||
                   idx == pats_pkg::LOCAL_BASE_THREE || idx == pats_pkg::GLOBAL_BASE_ONE ||
                   idx == pats_pkg::TRIGGER_TIME_BASE;
  endfunction

  // Base serving a channel: trigger channel on the trigger time base, phases on the PWM time base
  function automatic int base_of(input int ch);
    base_of = (ch == TRCH) ? 1 : 0;
  endfunction

  generate
    if (RES_W < 1 || RES_W > 16 || FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH || AW > 7)
      begin : g_bad
      $error("pats_top: unsupported RES_W or FIFO_DEPTH");
    end
    if (!is_time_base(CH_BASE[0]) || !is_time_base(CH_BASE[1])) begin : g_bad_base
      $error("pats_top: channel is not a time base");
    end
  endgenerate

  // ****************************************
  // Register file
  // ****************************************
  logic            run;
  logic            flag_both;
  logic            dbg_route;
  logic [CW-1:0]   per_sh  [2];
  logic [CW-1:0]   init_sh [2];
  logic [CW-1:0]   a_sh    [NCH];
  logic [CW-1:0]   b_sh    [NCH];
  logic [7:0]      dead_time;
  logic [7:0]      watermark;
  logic            overflow;
  logic            trig_flag;
  logic [AW:0]     level;
  logic [FW-1:0]   fifo_mem [FIFO_DEPTH];
  logic [AW-1:0]   wr_ptr;
  logic [AW-1:0]   rd_ptr;
  logic            fifo_push;
  logic [FW-1:0]   fifo_din;
  pats_pkg::pats_seq_t seq_state;
  logic [CW-1:0]   cnt [2];

  wire logic setup    = i_psel && !i_penable;
  wire logic wr_acc   = i_psel && i_penable && i_pwrite;
  wire logic fifo_pop = setup && !i_pwrite && i_paddr == pats_pkg::OFS_FIFO_DATA && level != '0;
  wire logic ovf_clr  = wr_acc && i_paddr == pats_pkg::OFS_STATUS && i_pwdata[pats_pkg::STAT_OVF];

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = a[1:0] == 2'h0 && a <= pats_pkg::OFS_COUNTERS;
  endfunction

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run        <= 1'b0;
      flag_both  <= 1'b0;
      dbg_route  <= 1'b0;
      per_sh[0]  <= pats_pkg::PWM_PERIOD_RST;
      per_sh[1]  <= pats_pkg::TRIG_PERIOD_RST;
      init_sh[0] <= '0;
      init_sh[1] <= '0;
      dead_time  <= pats_pkg::DEAD_TIME_RST;
      watermark  <= pats_pkg::WATERMARK_RST;
      for (int i = 0; i < NCH; i++) begin
        a_sh[i] <= '0;
        b_sh[i] <= '0;
      end
    end else if (wr_acc) begin
      unique case (i_paddr)
        pats_pkg::OFS_CTRL: begin
          run       <= i_pwdata[pats_pkg::CTRL_RUN];
          flag_both <= i_pwdata[pats_pkg::CTRL_BOTH];
          dbg_route <= i_pwdata[pats_pkg::CTRL_DEBUG];
        end
        pats_pkg::OFS_PWM_PERIOD:  per_sh[0]  <= i_pwdata[CW-1:0];
        pats_pkg::OFS_TRIG_PERIOD: per_sh[1]  <= i_pwdata[CW-1:0];
        pats_pkg::OFS_PWM_INIT:    init_sh[0] <= i_pwdata[CW-1:0];
        pats_pkg::OFS_TRIG_INIT:   init_sh[1] <= i_pwdata[CW-1:0];
        pats_pkg::OFS_DEAD_TIME:   dead_time  <= i_pwdata[7:0];
        pats_pkg::OFS_WATERMARK:   watermark  <= i_pwdata[7:0];
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (i_paddr == pats_pkg::OFS_CMP_BASE + 8'(i) * pats_pkg::CMP_STRIDE) begin
              a_sh[i] <= i_pwdata[CW-1:0];
              b_sh[i] <= i_pwdata[pats_pkg::CMP_B_LSB +: CW];
            end
          end
        end
      endcase
    end
  end

  // Read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= '0;
    end else if (setup && !i_pwrite) begin
      unique case (i_paddr)
        pats_pkg::OFS_CTRL:        o_prdata <= 32'({dbg_route, flag_both, run});
        pats_pkg::OFS_PWM_PERIOD:  o_prdata <= 32'(per_sh[0]);
        pats_pkg::OFS_TRIG_PERIOD: o_prdata <= 32'(per_sh[1]);
        pats_pkg::OFS_PWM_INIT:    o_prdata <= 32'(init_sh[0]);
        pats_pkg::OFS_TRIG_INIT:   o_prdata <= 32'(init_sh[1]);
        pats_pkg::OFS_DEAD_TIME:   o_prdata <= 32'(dead_time);
        pats_pkg::OFS_WATERMARK:   o_prdata <= 32'(watermark);
        pats_pkg::OFS_FIFO_DATA:   o_prdata <= (level != '0) ? 32'(fifo_mem[rd_ptr]) : '0;
        pats_pkg::OFS_STATUS:      o_prdata <= 32'({level, 4'h0,
                                      level == '0, overflow, seq_state != pats_pkg::SEQ_IDLE,
                                      trig_flag});
        pats_pkg::OFS_COUNTERS:    o_prdata <= {cnt[1], cnt[0]};
        default: begin
          o_prdata <= '0;
          for (int i = 0; i < NCH; i++) begin
            if (i_paddr == pats_pkg::OFS_CMP_BASE + 8'(i) * pats_pkg::CMP_STRIDE) begin
              o_prdata <= {b_sh[i], a_sh[i]};
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Time bases
  // ****************************************
  logic          run_d;
  logic [CW-1:0] per_act [2];
  logic          wrap    [2];
  wire  logic    start = run && !run_d;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_d <= 1'b0;
    end else begin
      run_d <= run;
    end
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      wrap[t] = run_d && run && cnt[t] >= per_act[t] - CW'(1);
    end
  end

  // Buffered modulus up-count, common start, initial value as offset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int t = 0; t < 2; t++) begin
        cnt[t]     <= '0;
        per_act[t] <= '0;
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (start) begin
          cnt[t]     <= init_sh[t];
          per_act[t] <= per_sh[t];
        end else if (wrap[t]) begin
          cnt[t]     <= '0;
          per_act[t] <= per_sh[t];
        end else if (run) begin
          cnt[t]     <= cnt[t] + CW'(1);
        end
      end
    end
  end

  // ****************************************
  // Buffered pulse-width output channels
  // ****************************************
  logic [CW-1:0] a_act [NCH];
  logic [CW-1:0] b_act [NCH];
  logic          ch_out [NCH];
  logic          match_a [NCH];
  logic          match_b [NCH];

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match_a[i] = run_d && run && cnt[base_of(i)] == a_act[i];
      match_b[i] = run_d && run && cnt[base_of(i)] == b_act[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        a_act[i]  <= '0;
        b_act[i]  <= '0;
        ch_out[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (start || wrap[base_of(i)]) begin
          a_act[i] <= a_sh[i];
          b_act[i] <= b_sh[i];
        end
        if (!run) begin
          ch_out[i] <= 1'b0;
        end else if (match_a[i]) begin
          ch_out[i] <= 1'b1;
        end else if (match_b[i]) begin
          ch_out[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_trig_debug <= 1'b0;
    end else begin
      o_trig_debug <= dbg_route && ch_out[TRCH];
    end
  end

  // ****************************************
  // Logic combiner with dead time
  // ****************************************
  logic       pwm_prev [3];
  logic [7:0] dt_cnt   [3];
  logic       hi_gate  [3];
  logic       lo_gate  [3];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 3; p++) begin
        pwm_prev[p] <= 1'b0;
        dt_cnt[p]   <= '0;
        hi_gate[p]  <= 1'b0;
        lo_gate[p]  <= 1'b0;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        pwm_prev[p] <= ch_out[p];
        if (ch_out[p] != pwm_prev[p]) begin
          dt_cnt[p] <= '0;
        end else if (dt_cnt[p] < dead_time) begin
          dt_cnt[p] <= dt_cnt[p] + 8'h01;
        end
        hi_gate[p] <= run && !ch_out[p] && ch_out[p] == pwm_prev[p] &&
                      dt_cnt[p] >= dead_time;
        lo_gate[p] <= run && ch_out[p] && ch_out[p] == pwm_prev[p] &&
                      dt_cnt[p] >= dead_time;
      end
    end
  end

  assign o_phase_a_high_gate = hi_gate[0];
  assign o_phase_a_low_gate  = lo_gate[0];
  assign o_phase_b_high_gate = hi_gate[1];
  assign o_phase_b_low_gate  = lo_gate[1];
  assign o_phase_c_high_gate = hi_gate[2];
  assign o_phase_c_low_gate  = lo_gate[2];

  // ****************************************
  // Trigger flag and conversion sequencer
  // ****************************************
  wire logic flag_set = match_b[TRCH] || (flag_both && match_a[TRCH]);
  wire logic flag_clr = seq_state == pats_pkg::SEQ_IDLE && trig_flag;
  logic             got0;
  logic             got1;
  logic [RES_W-1:0] res0;
  logic [RES_W-1:0] res1;
  wire  logic       cur_done = (got0 || i_converter_zero_done) && (got1 || i_converter_one_done);
  wire  logic [RES_W-1:0] cur0 = got0 ? res0 : i_converter_zero_data;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trig_flag <= 1'b0;
    end else begin
      trig_flag <= flag_set || (trig_flag && !flag_clr);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      seq_state <= pats_pkg::SEQ_IDLE;
      got0      <= 1'b0;
      got1      <= 1'b0;
      res0      <= '0;
      res1      <= '0;
    end else begin
      unique case (seq_state)
        pats_pkg::SEQ_IDLE: begin
          got0 <= 1'b0;
          got1 <= 1'b0;
          if (trig_flag) begin
            seq_state <= pats_pkg::SEQ_CURR;
          end
        end
        pats_pkg::SEQ_CURR: begin
          if (i_converter_zero_done && !got0) begin
            got0 <= 1'b1;
            res0 <= i_converter_zero_data;
          end
          if (i_converter_one_done && !got1) begin
            got1 <= 1'b1;
            res1 <= i_converter_one_data;
          end
          if (cur_done) begin
            seq_state <= pats_pkg::SEQ_PUSH;
          end
        end
        pats_pkg::SEQ_PUSH: seq_state <= pats_pkg::SEQ_VOLT;
        pats_pkg::SEQ_VOLT: begin
          if (i_converter_zero_done) begin
            seq_state <= pats_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Converter one: phase A current; converter zero: phase B, then DC bus
  always_comb begin
    o_converter_zero_start = flag_clr || seq_state == pats_pkg::SEQ_PUSH;
    o_converter_one_start  = flag_clr;
    o_conv_sel             = (seq_state == pats_pkg::SEQ_PUSH) ? pats_pkg::SEL_DCBUS
                                                               : pats_pkg::SEL_CURRENTS;
    fifo_push = 1'b0;
    fifo_din  = '0;
    if (seq_state == pats_pkg::SEQ_CURR && cur_done) begin
      fifo_push = 1'b1;
      fifo_din  = {pats_pkg::TAG_PHASE_B, 2'h0, cur0};
    end else if (seq_state == pats_pkg::SEQ_PUSH) begin
      fifo_push = 1'b1;
      fifo_din  = {pats_pkg::TAG_PHASE_A, 2'h0, res1};
    end else if (seq_state == pats_pkg::SEQ_VOLT && i_converter_zero_done) begin
      fifo_push = 1'b1;
      fifo_din  = {pats_pkg::TAG_DCBUS, 2'h0, i_converter_zero_data};
    end
  end

  // ****************************************
  // Result FIFO and watermark
  // ****************************************
  wire logic full   = level == (AW+1)'(FIFO_DEPTH);
  wire logic do_wr  = fifo_push && !full;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      fifo_mem[wr_ptr] <= fifo_din;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      level    <= '0;
      overflow <= 1'b0;
      o_watermark_irq <= 1'b0;
    end else begin
      wr_ptr   <= wr_ptr + AW'(do_wr);
      rd_ptr   <= rd_ptr + AW'(fifo_pop);
      level    <= level + (AW+1)'(do_wr) - (AW+1)'(fifo_pop);
      overflow <= (fifo_push && full) || (overflow && !ovf_clr);
      o_watermark_irq <= watermark != '0 && 8'(level) >= watermark;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_trig_accept;
    seq_state == pats_pkg::SEQ_IDLE && trig_flag;
  endsequence
  sequence s_currents_done;
    seq_state == pats_pkg::SEQ_CURR && cur_done;
  endsequence

  a_flag_holds: assert property (trig_flag && !flag_clr |=> trig_flag)
    else $error("trigger flag dropped before acceptance");
  a_flag_on_b: assert property (match_b[TRCH] |=> trig_flag)
    else $error("trigger flag not set on B match");
  a_flag_on_a: assert property (flag_both && match_a[TRCH] |=> trig_flag)
    else $error("trigger flag not set on A match");
  a_seq_launch: assert property (s_trig_accept |->
      o_converter_zero_start && o_converter_one_start &&
      o_conv_sel == pats_pkg::SEL_CURRENTS ##1 seq_state == pats_pkg::SEQ_CURR)
    else $error("conversion list not started by flag");
  a_dcbus_next: assert property (s_currents_done |=>
      o_converter_zero_start && o_conv_sel == pats_pkg::SEL_DCBUS ##1
      seq_state == pats_pkg::SEQ_VOLT)
    else $error("DC-bus conversion did not follow currents");
  a_base_wrap: assert property (wrap[0] && !start |=>
      cnt[0] == '0 && per_act[0] == $past(per_sh[0]))
    else $error("time base did not wrap and reload");
  a_start_offset: assert property (start |=>
      cnt[0] == $past(init_sh[0]) && cnt[1] == $past(init_sh[1]))
    else $error("time bases did not start at initial values");
  a_cmp_reload: assert property (wrap[0] && !start |=>
      a_act[0] == $past(a_sh[0]) && b_act[1] == $past(b_sh[1]))
    else $error("compare values not reloaded at wrap");
  a_edge_a_set: assert property (match_a[0] |=> ch_out[0])
    else $error("A match did not set output");
  a_gate_dead: assert property (ch_out[0] != pwm_prev[0] |=>
      !hi_gate[0] && !lo_gate[0])
    else $error("gate on without dead time");
  a_gate_excl: assert property (!(hi_gate[1] && lo_gate[1]) &&
      (!lo_gate[2] || $past(ch_out[2])))
    else $error("gate pair overlaps or wrong polarity");
  a_irq_level: assert property (watermark != '0 && 8'(level) >= watermark
      |=> o_watermark_irq)
    else $error("watermark interrupt missing");
endmodule
`default_nettype wire

// ---- tb/pats_conv_model.sv ----
// Converter pair model answering start pulses after a fixed latency
`default_nettype none
module pats_conv_model (
  input  wire logic        i_clk,
  input  wire logic        i_start0,
  input  wire logic        i_start1,
  input  wire logic        i_sel,
  output logic             o_done0,
  output logic             o_done1,
  output logic [11:0]      o_data0,
  output logic [11:0]      o_data1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] c0 = 3'h0;
  logic [2:0] c1 = 3'h0;
  logic       s0 = 1'b0;
  initial begin
    o_done0 = 1'b0;
    o_done1 = 1'b0;
    o_data0 = 12'h000;
    o_data1 = 12'h000;
  end
  // Data only valid with done, scrambled otherwise
  always @(posedge i_clk) begin
    c0 <= i_start0 ? 3'h3 : (c0 != 3'h0 ? c0 - 3'h1 : c0);
    c1 <= i_start1 ? 3'h5 : (c1 != 3'h0 ? c1 - 3'h1 : c1);
    if (i_start0) s0 <= i_sel;
    o_done0 <= (c0 == 3'h1);
    o_done1 <= (c1 == 3'h1);
    o_data0 <= (c0 == 3'h1) ? (s0 ? 12'h0dc : 12'h0b1) : ~o_data0;
    o_data1 <= (c1 == 3'h1) ? 12'h0a1 : ~o_data1;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the PWM and conversion-trigger block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, prdata, r;
  logic        pready, pslverr, se, dbg, irq, s0, s1, sel, d0, d1, seen_dbg = 1'b0;
  wire  [2:0]  hg, lg;
  logic [11:0] dt0, dt1;
  int          err_count = 0, total_checks = 0, n;
  pats_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_paddr(pa), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwd), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_phase_a_high_gate(hg[0]),
    .o_phase_a_low_gate(lg[0]), .o_phase_b_high_gate(hg[1]), .o_phase_b_low_gate(lg[1]),
    .o_phase_c_high_gate(hg[2]), .o_phase_c_low_gate(lg[2]), .o_trig_debug(dbg),
    .o_converter_zero_start(s0), .o_converter_one_start(s1), .o_conv_sel(sel),
    .i_converter_zero_done(d0), .i_converter_zero_data(dt0),
    .i_converter_one_done(d1), .i_converter_one_data(dt1), .o_watermark_irq(irq));
  pats_conv_model cm_u (.i_clk(i_clk), .i_start0(s0), .i_start1(s1), .i_sel(sel),
    .o_done0(d0), .o_done1(d1), .o_data0(dt0), .o_data1(dt1));
  initial forever #20 i_clk = ~i_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pa <= a;
    pwr <= w;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  // Gate on-time of one phase: high side when hs is set, else low side
  task width(input logic hs, input int i, input int e);
    @(negedge i_clk iff (hs ? hg[i] : lg[i]) === 1'b0);
    @(negedge i_clk iff (hs ? hg[i] : lg[i]) === 1'b1);
    n = 0;
    while ((hs ? hg[i] : lg[i]) === 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    chk(n, e);
    @(posedge i_clk);
  endtask
  // Converter one start pulses over two trigger periods
  task starts(input int e);
    n = 0;
    repeat (64) begin
      @(negedge i_clk);
      if (s1 === 1'b1) n++;
    end
    chk(n, e);
    @(posedge i_clk);
  endtask
  always @(negedge i_clk) begin
    if (i_rst_n) chk({29'h0, hg & lg}, 32'h0);
    if (dbg === 1'b1) seen_dbg <= 1'b1;
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, pats_pkg::OFS_PWM_PERIOD, 32'h0);
    chk(r, 32'(pats_pkg::PWM_PERIOD_RST));
    apb(1'b0, pats_pkg::OFS_TRIG_PERIOD, 32'h0);
    chk(r, 32'(pats_pkg::TRIG_PERIOD_RST));
    apb(1'b0, pats_pkg::OFS_DEAD_TIME, 32'h0);
    chk(r, 32'(pats_pkg::DEAD_TIME_RST));
    apb(1'b0, 8'h38, 32'h0);
    chk({r[30:0], se}, 32'h1);
    apb(1'b1, pats_pkg::OFS_PWM_PERIOD, 32'h10);
    apb(1'b1, pats_pkg::OFS_TRIG_PERIOD, 32'h20);
    apb(1'b1, 8'h14, 32'h000c_0004);
    apb(1'b1, 8'h18, 32'h000b_0005);
    apb(1'b1, 8'h1c, 32'h000e_0002);
    apb(1'b1, 8'h20, 32'h0008_0002);
    apb(1'b1, pats_pkg::OFS_DEAD_TIME, 32'h2);
    apb(1'b1, pats_pkg::OFS_CTRL, 32'h5);
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    @(posedge i_clk);
    apb(1'b0, pats_pkg::OFS_FIFO_DATA, 32'h0);
    chk(r, 32'h40b1);
    apb(1'b0, pats_pkg::OFS_FIFO_DATA, 32'h0);
    chk(r, 32'h00a1);
    apb(1'b0, pats_pkg::OFS_FIFO_DATA, 32'h0);
    chk(r, 32'h80dc);
    apb(1'b0, pats_pkg::OFS_COUNTERS, 32'h0);
    chk(32'(r[31:16]) % 32'h10, 32'(r[15:0]));
    width(1'b0, 0, 12 - 4 - 2 - 1);
    width(1'b0, 1, 11 - 5 - 2 - 1);
    width(1'b0, 2, 14 - 2 - 2 - 1);
    apb(1'b1, 8'h14, 32'h000b_0005);
    width(1'b0, 0, 12 - 4 - 2 - 1);
    width(1'b0, 0, 11 - 5 - 2 - 1);
    width(1'b1, 1, 16 - (11 - 5) - 2 - 1);
    chk({31'h0, seen_dbg}, 32'h1);
    starts(2);
    apb(1'b1, pats_pkg::OFS_CTRL, 32'h3);
    repeat (32) @(posedge i_clk);
    starts(4);
    chk({31'h0, dbg}, 32'h0);
    conclude;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
